// ### rtl/pbco_map.svh
// constants for the port b / port c alternate-function override block
// assumes ports are 8 bits wide and port c sits above port b in pin vectors
`ifndef PBCO_MAP_SVH
`define PBCO_MAP_SVH
// port b pin positions
`define PBCO_B_SCK 7
`define PBCO_B_MISO 6
`define PBCO_B_MOSI 5
`define PBCO_B_SS 4
`define PBCO_B_CMP 3
`define PBCO_B_EXTINT 2
`define PBCO_B_CNT1 1
`define PBCO_B_UCLK 0
// port c pin positions
`define PBCO_C_OSCOUT 7
`define PBCO_C_OSCIN 6
`define PBCO_C_TDI 5
`define PBCO_C_TDO 4
`define PBCO_C_TMS 3
`define PBCO_C_TCK 2
`define PBCO_C_SDA 1
// index of port c bit 0 in the joined pin vectors
`define PBCO_C_BASE 8
// reset values of the registered pin outputs
`define PBCO_ZERO_RST 8'h00
`define PBCO_C_PULL_RST 8'h2C
`endif

// ### rtl/pbco_pkg.sv
// types shared by the port b / port c override block
// assumes the constants header is included by each user
package pbco_pkg;
  // one 8-bit port
  typedef logic [7:0] pbco_byte_t;
  // tap controller states, tracked from the sampled test clock
  typedef enum {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EX1_IR,
    TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } pbco_tap_state_t;
endpackage

// ### rtl/pbco_pin_cell.sv
// one pin's override combiner: pull-up, driver, value and input enable
// assumes all inputs are synchronous levels; purely combinational
`timescale 1ns/10ps
`default_nettype none
module pbco_pin_cell (
  input wire logic portOut,
  input wire logic dirBit,
  input wire logic pullDisable,
  input wire logic sleepInputOff,
  input wire logic pullupOverrideEnable,
  input wire logic pullupOverrideValue,
  input wire logic directionOverrideEnable,
  input wire logic directionOverrideValue,
  input wire logic valueOverrideEnable,
  input wire logic valueOverrideValue,
  input wire logic inputEnableOverrideEnable,
  input wire logic inputEnableOverrideValue,
  output logic pullupOn,
  output logic driveOn,
  output logic driveVal,
  output logic inputOn
);
  // ordinary pull-up: input pin with output bit set, killed by global disable
  logic plainPull; // [R21]
  assign plainPull = !dirBit && portOut && !pullDisable; // [R21]
  // each override enable picks its value, else the ordinary port path
  assign pullupOn = pullupOverrideEnable ? pullupOverrideValue : plainPull; // [R23]
  assign driveOn = directionOverrideEnable ? directionOverrideValue : dirBit; // [R23]
  // value override only matters while the driver is on
  assign driveVal = valueOverrideEnable ? valueOverrideValue : portOut; // [R22]
  // sleep gating applies unless overridden
  assign inputOn = inputEnableOverrideEnable ? inputEnableOverrideValue
                                             : !sleepInputOff; // [R23]
endmodule
`default_nettype wire

// ### rtl/pbco_tap_tracker.sv
// follows the tap controller from sampled test clock and mode select
// assumes tck and tms are synchronous samples, far slower than clk
`timescale 1ns/10ps
`default_nettype none
module pbco_tap_tracker
  import pbco_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic jtagOn,
  input wire logic tckIn,
  input wire logic tmsIn,
  output logic shiftActive
);
  logic tckPrev_reg; // last tck sample
  logic tckRise; // one-cycle rising edge of tck
  pbco_tap_state_t state_reg; // current tap state
  pbco_tap_state_t state_next; // state after this tck edge
  // edge detect on the sampled test clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // tck rests high on its pull-up, so no false rise follows reset
      tckPrev_reg <= 1'b1;
    end else begin
      tckPrev_reg <= tckIn;
    end
  end
  assign tckRise = tckIn && !tckPrev_reg; // [R18]
  // tms steers the walk, one step per tck rise
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TAP_RESET: state_next = tmsIn ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_next = tmsIn ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_next = tmsIn ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_next = tmsIn ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_next = tmsIn ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_EX1_DR: state_next = tmsIn ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_next = tmsIn ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR: state_next = tmsIn ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: state_next = tmsIn ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_next = tmsIn ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_next = tmsIn ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_next = tmsIn ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_EX1_IR: state_next = tmsIn ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_next = tmsIn ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR: state_next = tmsIn ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: state_next = tmsIn ? TAP_SEL_DR : TAP_IDLE;
      default: state_next = TAP_RESET;
    endcase
  end
  // state register; held in reset while jtag is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TAP_RESET;
    end else if (!jtagOn) begin
      state_reg <= TAP_RESET;
    end else if (tckRise) begin
      state_reg <= state_next; // [R18]
    end
  end
  // only the two shift states send data out
  assign shiftActive = (state_reg == TAP_SHIFT_DR) || (state_reg == TAP_SHIFT_IR); // [R17]
endmodule
`default_nettype wire

// ### rtl/pbco_override.sv
// port b / port c alternate-function override, registered pin side
// assumes all peripheral and pin inputs are synchronous to clk
// How it works
// R1 - spi slave forces sck, mosi, ss inputs
// R2 - spi master leaves those directions to port
// R3 - miso input as master, port direction as slave
// R4 - forced spi inputs keep port pull-up control
// R5 - spi slave active only while ss low
// R6 - miso and mosi carry spi data both ways
// R7 - compare output drives bit 3 when direction set
// R8 - bit 3 also carries timer0 pwm output
// R9 - interrupt 2 enable forces bit 2 input on
// R10 - software keeps comparator pins input, no pull-up
// R11 - bit 0 direction picks usart clock direction
// R12 - usart clock only in synchronous mode
// R13 - bits 1 and 0 feed timer count sources
// R14 - jtag pull-ups stay on, even in reset
// R15 - async timer2 detaches port c bits 7,6
// R16 - jtag owns port c bits 5 to 2
// R17 - tdo driven only in shift states
// R18 - jtag steps on test clock edges
// R19 - two-wire enable makes bit 1 open-drain data
// R20 - two-wire data pull-up follows port bit
// R21 - global disable kills every ordinary pull-up
// R22 - value override replaces output bit when driving
// R23 - no override means ordinary port behaviour
`timescale 1ns/10ps
`default_nettype none
`include "pbco_map.svh"
module pbco_override
  import pbco_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire pbco_byte_t outBitsB,
  input wire pbco_byte_t dirBitsB,
  input wire pbco_byte_t outBitsC,
  input wire pbco_byte_t dirBitsC,
  input wire logic globalPullupDisable,
  input wire logic sleepInputDisable,
  input wire logic spiEnableBit,
  input wire logic spiMasterSelect,
  input wire logic spiClockOut,
  input wire logic spiMasterOut,
  input wire logic spiSlaveOut,
  input wire logic timer0CompareEnable,
  input wire logic timer0CompareOutput,
  input wire logic extInterrupt2Enable,
  input wire logic usartModeSelect,
  input wire logic usartSyncClockOut,
  input wire logic timer2AsyncSelect,
  input wire logic jtagEnable,
  input wire logic jtagTdoData,
  input wire logic twoWireEnableBit,
  input wire logic twoWireDataPullLow,
  input wire pbco_byte_t pinInB,
  input wire pbco_byte_t pinInC,
  output pbco_byte_t pinOutB,
  output pbco_byte_t pinOeB,
  output pbco_byte_t pinPullupB,
  output pbco_byte_t pinOutC,
  output pbco_byte_t pinOeC,
  output pbco_byte_t pinPullupC,
  output pbco_byte_t portInB,
  output pbco_byte_t portInC,
  output logic spiClockIn,
  output logic spiMasterIn,
  output logic spiSlaveIn,
  output logic spiSlaveActive,
  output logic extInterrupt2Input,
  output logic comparatorPositiveInput,
  output logic comparatorNegativeInput,
  output logic timer0CountSource,
  output logic timer1CountSource,
  output logic usartSyncClockIn,
  output logic jtagTdiIn,
  output logic jtagTmsIn,
  output logic jtagTckIn,
  output logic tdoShiftActive,
  output logic twoWireDataIn
);
  // joined vectors: port b in bits 7..0, port c in bits 15..8
  logic [15:0] pullSel; // pull-up override enables
  logic [15:0] pullVal; // pull-up override values
  logic [15:0] dirSel; // direction override enables
  logic [15:0] dirVal; // direction override values
  logic [15:0] outSel; // value override enables
  logic [15:0] outVal; // value override values
  logic [15:0] inSel; // input enable override enables
  logic [15:0] inVal; // input enable override values
  logic [15:0] outJoin; // port output bits
  logic [15:0] dirJoin; // port direction bits
  logic [15:0] pinJoin; // raw pin levels
  logic [15:0] pullNext; // combined pull-up per pin
  logic [15:0] driveNext; // combined driver enable
  logic [15:0] valNext; // combined output value
  logic [15:0] inOnNext; // combined digital input enable
  logic [15:0] digIn; // gated digital input
  logic spiSlave; // spi on as slave
  logic spiMaster; // spi on as master
  logic tapShift; // tap in a shift state
  logic pullOffB; // port b pull-up term, global disable folded in

  assign outJoin = {outBitsC, outBitsB};
  assign dirJoin = {dirBitsC, dirBitsB};
  assign pinJoin = {pinInC, pinInB};
  assign spiSlave = spiEnableBit && !spiMasterSelect;
  assign spiMaster = spiEnableBit && spiMasterSelect;
  assign pullOffB = globalPullupDisable;

  // tap tracker for the tdo driver
  pbco_tap_tracker uTap (
    .clk(clk),
    .rst_b(rst_b),
    .jtagOn(jtagEnable),
    .tckIn(pinInC[`PBCO_C_TCK]),
    .tmsIn(pinInC[`PBCO_C_TMS]),
    .shiftActive(tapShift)
  );

  // override table for port b and port c
  always_comb begin
    pullSel = '0;
    pullVal = '0;
    dirSel = '0;
    dirVal = '0;
    outSel = '0;
    outVal = '0;
    inSel = '0;
    inVal = '0;
    // sck: slave forces input, master drives clock value
    pullSel[`PBCO_B_SCK] = spiSlave; // [R1]
    pullVal[`PBCO_B_SCK] = outBitsB[`PBCO_B_SCK] && !pullOffB; // [R4]
    dirSel[`PBCO_B_SCK] = spiSlave; // [R1] [R2]
    outSel[`PBCO_B_SCK] = spiMaster;
    outVal[`PBCO_B_SCK] = spiClockOut;
    // miso: master forces input, slave drives its serial output
    pullSel[`PBCO_B_MISO] = spiMaster; // [R3]
    pullVal[`PBCO_B_MISO] = outBitsB[`PBCO_B_MISO] && !pullOffB; // [R4]
    dirSel[`PBCO_B_MISO] = spiMaster; // [R3]
    outSel[`PBCO_B_MISO] = spiSlave; // [R6]
    outVal[`PBCO_B_MISO] = spiSlaveOut; // [R6]
    // mosi: slave forces input, master drives its serial output
    pullSel[`PBCO_B_MOSI] = spiSlave; // [R1]
    pullVal[`PBCO_B_MOSI] = outBitsB[`PBCO_B_MOSI] && !pullOffB; // [R4]
    dirSel[`PBCO_B_MOSI] = spiSlave; // [R1] [R2]
    outSel[`PBCO_B_MOSI] = spiMaster; // [R6]
    outVal[`PBCO_B_MOSI] = spiMasterOut; // [R6]
    // ss: slave forces input, never driven by the spi
    pullSel[`PBCO_B_SS] = spiSlave; // [R1]
    pullVal[`PBCO_B_SS] = outBitsB[`PBCO_B_SS] && !pullOffB; // [R4]
    dirSel[`PBCO_B_SS] = spiSlave; // [R1] [R2]
    // compare/pwm output: direction stays the port's, so dir bit gates it
    outSel[`PBCO_B_CMP] = timer0CompareEnable; // [R7] [R8]
    outVal[`PBCO_B_CMP] = timer0CompareOutput; // [R7] [R8]
    // interrupt 2 keeps its input alive through sleep
    inSel[`PBCO_B_EXTINT] = extInterrupt2Enable; // [R9]
    inVal[`PBCO_B_EXTINT] = 1'b1; // [R9]
    // usart clock value only in synchronous mode; dir bit picks direction
    outSel[`PBCO_B_UCLK] = usartModeSelect; // [R11] [R12]
    outVal[`PBCO_B_UCLK] = usartSyncClockOut; // [R12]
    // port c: oscillator pins detached under async timer2
    pullSel[`PBCO_C_BASE+`PBCO_C_OSCOUT] = timer2AsyncSelect; // [R15]
    dirSel[`PBCO_C_BASE+`PBCO_C_OSCOUT] = timer2AsyncSelect; // [R15]
    inSel[`PBCO_C_BASE+`PBCO_C_OSCOUT] = timer2AsyncSelect; // [R15]
    pullSel[`PBCO_C_BASE+`PBCO_C_OSCIN] = timer2AsyncSelect; // [R15]
    dirSel[`PBCO_C_BASE+`PBCO_C_OSCIN] = timer2AsyncSelect; // [R15]
    inSel[`PBCO_C_BASE+`PBCO_C_OSCIN] = timer2AsyncSelect; // [R15]
    // tdi, tms, tck: inputs with pull-up held on
    pullSel[`PBCO_C_BASE+`PBCO_C_TDI] = jtagEnable; // [R16]
    pullVal[`PBCO_C_BASE+`PBCO_C_TDI] = 1'b1; // [R14]
    dirSel[`PBCO_C_BASE+`PBCO_C_TDI] = jtagEnable; // [R16]
    inSel[`PBCO_C_BASE+`PBCO_C_TDI] = jtagEnable; // [R16]
    pullSel[`PBCO_C_BASE+`PBCO_C_TMS] = jtagEnable; // [R16]
    pullVal[`PBCO_C_BASE+`PBCO_C_TMS] = 1'b1; // [R14]
    dirSel[`PBCO_C_BASE+`PBCO_C_TMS] = jtagEnable; // [R16]
    inSel[`PBCO_C_BASE+`PBCO_C_TMS] = jtagEnable; // [R16]
    pullSel[`PBCO_C_BASE+`PBCO_C_TCK] = jtagEnable; // [R16]
    pullVal[`PBCO_C_BASE+`PBCO_C_TCK] = 1'b1; // [R14]
    dirSel[`PBCO_C_BASE+`PBCO_C_TCK] = jtagEnable; // [R16]
    inSel[`PBCO_C_BASE+`PBCO_C_TCK] = jtagEnable; // [R16]
    // tdo: driven only while shifting
    pullSel[`PBCO_C_BASE+`PBCO_C_TDO] = jtagEnable; // [R16]
    dirSel[`PBCO_C_BASE+`PBCO_C_TDO] = jtagEnable; // [R16]
    dirVal[`PBCO_C_BASE+`PBCO_C_TDO] = tapShift; // [R17]
    outSel[`PBCO_C_BASE+`PBCO_C_TDO] = jtagEnable; // [R16]
    outVal[`PBCO_C_BASE+`PBCO_C_TDO] = jtagTdoData; // [R16]
    inSel[`PBCO_C_BASE+`PBCO_C_TDO] = jtagEnable; // [R16]
    // sda: open drain, only ever drives low, pull-up stays the port's
    pullSel[`PBCO_C_BASE+`PBCO_C_SDA] = twoWireEnableBit; // [R19]
    pullVal[`PBCO_C_BASE+`PBCO_C_SDA] = outBitsC[`PBCO_C_SDA] && !pullOffB; // [R20] [R21]
    dirSel[`PBCO_C_BASE+`PBCO_C_SDA] = twoWireEnableBit; // [R19]
    dirVal[`PBCO_C_BASE+`PBCO_C_SDA] = twoWireDataPullLow; // [R19]
    outSel[`PBCO_C_BASE+`PBCO_C_SDA] = twoWireEnableBit; // [R19]
  end

  // one combiner per pin
  for (genvar i = 0; i < 16; i++) begin : gPin
    pbco_pin_cell uCell (
      .portOut(outJoin[i]),
      .dirBit(dirJoin[i]),
      .pullDisable(globalPullupDisable),
      .sleepInputOff(sleepInputDisable),
      .pullupOverrideEnable(pullSel[i]),
      .pullupOverrideValue(pullVal[i]),
      .directionOverrideEnable(dirSel[i]),
      .directionOverrideValue(dirVal[i]),
      .valueOverrideEnable(outSel[i]),
      .valueOverrideValue(outVal[i]),
      .inputEnableOverrideEnable(inSel[i]),
      .inputEnableOverrideValue(inVal[i]),
      .pullupOn(pullNext[i]),
      .driveOn(driveNext[i]),
      .driveVal(valNext[i]),
      .inputOn(inOnNext[i])
    );
  end

  // digital input path, gated by the combined input enable
  assign digIn = pinJoin & inOnNext; // [R23]

  // pin drivers and pull-ups, one register stage to the pads
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOutB <= `PBCO_ZERO_RST;
      pinOeB <= `PBCO_ZERO_RST;
      pinPullupB <= `PBCO_ZERO_RST;
      pinOutC <= `PBCO_ZERO_RST;
      pinOeC <= `PBCO_ZERO_RST;
      // jtag pull-ups are held on through reset; the fuse cannot be sampled here
      pinPullupC <= `PBCO_C_PULL_RST; // [R14]
    end else begin
      pinOutB <= valNext[7:0]; // [R22]
      pinOeB <= driveNext[7:0]; // [R1] [R2] [R3]
      pinPullupB <= pullNext[7:0]; // [R21]
      pinOutC <= valNext[15:8]; // [R22]
      pinOeC <= driveNext[15:8]; // [R17]
      pinPullupC <= pullNext[15:8]; // [R14] [R20]
    end
  end

  // port read-back of the gated input levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portInB <= `PBCO_ZERO_RST;
      portInC <= `PBCO_ZERO_RST;
    end else begin
      portInB <= digIn[7:0];
      portInC <= digIn[15:8];
    end
  end

  // spi inputs; ss is the raw level so sleep gating cannot fake a select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spiClockIn <= 1'b0;
      spiMasterIn <= 1'b0;
      spiSlaveIn <= 1'b0;
      spiSlaveActive <= 1'b0;
    end else begin
      spiClockIn <= digIn[`PBCO_B_SCK];
      spiMasterIn <= digIn[`PBCO_B_MISO]; // [R6]
      spiSlaveIn <= digIn[`PBCO_B_MOSI]; // [R6]
      spiSlaveActive <= spiSlave && !pinInB[`PBCO_B_SS]; // [R5]
    end
  end

  // timer, interrupt, usart and comparator inputs
  // comparator sees the raw pad; keeping it quiet is software's job [R10]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extInterrupt2Input <= 1'b0;
      comparatorPositiveInput <= 1'b0;
      comparatorNegativeInput <= 1'b0;
      timer0CountSource <= 1'b0;
      timer1CountSource <= 1'b0;
      usartSyncClockIn <= 1'b0;
    end else begin
      extInterrupt2Input <= digIn[`PBCO_B_EXTINT]; // [R9]
      comparatorPositiveInput <= pinInB[`PBCO_B_EXTINT];
      comparatorNegativeInput <= pinInB[`PBCO_B_CMP];
      timer0CountSource <= digIn[`PBCO_B_UCLK]; // [R13]
      timer1CountSource <= digIn[`PBCO_B_CNT1]; // [R13]
      usartSyncClockIn <= digIn[`PBCO_B_UCLK]; // [R11]
    end
  end

  // jtag and two-wire inputs; jtag pins bypass the input gating on purpose
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jtagTdiIn <= 1'b0;
      jtagTmsIn <= 1'b0;
      jtagTckIn <= 1'b0;
      tdoShiftActive <= 1'b0;
      twoWireDataIn <= 1'b0;
    end else begin
      jtagTdiIn <= jtagEnable && pinInC[`PBCO_C_TDI]; // [R16]
      jtagTmsIn <= jtagEnable && pinInC[`PBCO_C_TMS]; // [R18]
      jtagTckIn <= jtagEnable && pinInC[`PBCO_C_TCK]; // [R18]
      tdoShiftActive <= tapShift; // [R17]
      twoWireDataIn <= twoWireEnableBit && digIn[`PBCO_C_BASE+`PBCO_C_SDA]; // [R19]
    end
  end

  // checks on the registered pin side
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_spiSlave;
    spiEnableBit && !spiMasterSelect;
  endsequence
  sequence s_spiMaster;
    spiEnableBit && spiMasterSelect;
  endsequence

  a_slave_pins_input: assert property (s_spiSlave |=> !pinOeB[7] && !pinOeB[5] && !pinOeB[4]) // [R1]
    else $error("spi slave pin driven");
  a_master_dir_follow: assert property (s_spiMaster |=> pinOeB[7] == $past(dirBitsB[7])) // [R2]
    else $error("spi master sck direction wrong");
  a_miso_master_in: assert property (s_spiMaster |=> !pinOeB[6]) // [R3]
    else $error("miso driven as master");
  a_spi_pullup_kept: assert property (s_spiSlave ##0 (outBitsB[5] && !globalPullupDisable)
      |=> pinPullupB[5]) // [R4]
    else $error("forced input lost pull-up");
  a_slave_select: assert property (spiSlaveActive |-> $past(!pinInB[4] && spiEnableBit)) // [R5]
    else $error("slave active without select");
  a_compare_drive: assert property (timer0CompareEnable && dirBitsB[3]
      |=> pinOeB[3] && pinOutB[3] == $past(timer0CompareOutput)) // [R7]
    else $error("compare output not on pin");
  a_ext_int_awake: assert property (extInterrupt2Enable && sleepInputDisable // [R9]
      |=> extInterrupt2Input == $past(pinInB[2]))
    else $error("interrupt 2 input lost in sleep");
  a_osc_detach: assert property (timer2AsyncSelect // [R15]
      |=> !pinOeC[7] && !pinOeC[6] && !pinPullupC[6])
    else $error("oscillator pin not detached");
  a_tdo_tristate: assert property (jtagEnable && !tapShift |=> !pinOeC[4]) // [R17]
    else $error("tdo driven outside shift");
  a_twi_pullup: assert property (twoWireEnableBit
      |=> pinPullupC[1] == $past(outBitsC[1] && !globalPullupDisable)) // [R20]
    else $error("sda pull-up wrong");
  a_pull_global_off: assert property (globalPullupDisable && !jtagEnable ##1 globalPullupDisable
      |-> pinPullupB == 8'h00) // [R21]
    else $error("pull-up on under global disable");
endmodule
`default_nettype wire

// ### bench/pbco_pad_model.sv
// pad model for port b and port c: resolves each pin level from the block's
// driver, its pull-up and an external device; assumes the bench drives ext* off the edge
`timescale 1ns/10ps
`default_nettype none
module pbco_pad_model
  import pbco_pkg::*;
(
  input wire logic clk,
  input wire pbco_byte_t pinOutB,
  input wire pbco_byte_t pinOeB,
  input wire pbco_byte_t pinPullupB,
  input wire pbco_byte_t pinOutC,
  input wire pbco_byte_t pinOeC,
  input wire pbco_byte_t pinPullupC,
  input wire logic [15:0] extDrive,
  input wire logic [15:0] extLevel,
  output pbco_byte_t padB,
  output pbco_byte_t padC
);
  // a floating pin changes every cycle so a stale level never passes
  logic floatLvl = 1'b0;
  logic [15:0] padAll; // resolved levels, {c,b}
  logic [15:0] oeAll; // joined driver enables, {c,b}
  logic [15:0] outAll; // joined driver values, {c,b}
  logic [15:0] pullAll; // joined pull-ups, {c,b}
  assign oeAll = {pinOeC, pinOeB};
  assign outAll = {pinOutC, pinOutB};
  assign pullAll = {pinPullupC, pinPullupB};
  // toggle pattern for undriven, unpulled pins
  always_ff @(posedge clk) begin
    floatLvl <= ~floatLvl;
  end
  // block driver first, then the external device, then the pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oeAll[i]) begin
        padAll[i] = outAll[i]; // open-drain data drives only low
      end else if (extDrive[i]) begin
        padAll[i] = extLevel[i];
      end else if (pullAll[i]) begin
        padAll[i] = 1'b1; // released data line rests on its pull-up
      end else begin
        padAll[i] = floatLvl;
      end
    end
  end
  assign padB = padAll[7:0];
  assign padC = padAll[15:8];
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the port b / port c override block
// assumes every block output is registered, one cycle after its inputs, two after a tck rise for the tdo outputs
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pbco_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pbco_byte_t outBitsB, dirBitsB, outBitsC, dirBitsC, pinInB, pinInC;
  pbco_byte_t pinOutB, pinOeB, pinPullupB, pinOutC, pinOeC, pinPullupC, portInB, portInC;
  logic globalPullupDisable, sleepInputDisable, spiEnableBit, spiMasterSelect, spiClockOut;
  logic spiMasterOut, spiSlaveOut, timer0CompareEnable, timer0CompareOutput;
  logic extInterrupt2Enable, usartModeSelect, usartSyncClockOut, timer2AsyncSelect;
  logic jtagEnable, jtagTdoData, twoWireEnableBit, twoWireDataPullLow;
  logic spiClockIn, spiMasterIn, spiSlaveIn, spiSlaveActive, extInterrupt2Input;
  logic comparatorPositiveInput, comparatorNegativeInput, timer0CountSource;
  logic timer1CountSource, usartSyncClockIn, jtagTdiIn, jtagTmsIn, jtagTckIn;
  logic tdoShiftActive, twoWireDataIn;
  logic [15:0] extDrive, extLevel; // external device on {c,b} pins
  int miscompares = 0;
  int nChecks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  pbco_override dut (.*);
  pbco_pad_model pads (.clk(clk), .pinOutB(pinOutB), .pinOeB(pinOeB),
    .pinPullupB(pinPullupB), .pinOutC(pinOutC), .pinOeC(pinOeC), .pinPullupC(pinPullupC),
    .extDrive(extDrive), .extLevel(extLevel), .padB(pinInB), .padC(pinInC));
  // n edges, then a small fixed delay so inputs never move on the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one comparison; case inequality so unknowns fail
  task automatic chk(input pbco_byte_t seen, input pbco_byte_t exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one test clock pulse: tck low with tms set, then high; pads c3 tms, c2 tck
  task automatic tckPulse(input logic tms);
    extLevel[11:10] = {tms, 1'b0};
    step(4);
    extLevel[10] = 1'b1;
    step(4);
  endtask
  // verdict and end of run
  task automatic finalReport;
    if (miscompares == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the sequence needs well under 500 cycles
  initial begin
    #20000;
    miscompares++;
    finalReport;
  end
  // main sequence
  initial begin
    {outBitsB, dirBitsB, outBitsC, dirBitsC, extDrive, extLevel} = '0;
    {globalPullupDisable, sleepInputDisable, spiEnableBit, spiMasterSelect, spiClockOut,
     spiMasterOut, spiSlaveOut, timer0CompareEnable, timer0CompareOutput,
     extInterrupt2Enable, usartModeSelect, usartSyncClockOut, timer2AsyncSelect,
     jtagEnable, jtagTdoData, twoWireEnableBit, twoWireDataPullLow} = '0;
    step(11);
    chk(pinPullupC, 8'h2C);
    step(1);
    rst_b = 1'b1;
    // ordinary port behaviour, then the global pull-up kill
    dirBitsB = 8'h0F;
    outBitsB = 8'hFF;
    step(2);
    chk(pinOeB, 8'h0F);
    chk(pinPullupB, 8'hF0);
    globalPullupDisable = 1'b1;
    step(2);
    chk(pinPullupB, 8'h00);
    // spi slave: sck, mosi, ss forced in; miso follows its bit
    globalPullupDisable = 1'b0;
    {spiEnableBit, spiSlaveOut, dirBitsB, outBitsB} = {2'b11, 8'hFF, 8'hB0};
    extDrive = 16'h00B0;
    extLevel = 16'h00A0;
    step(2);
    chk(pinOeB, 8'h4F);
    chk(pinPullupB, 8'hB0);
    chk(pinOutB[6], 1'b1);
    chk({spiSlaveIn, spiClockIn, spiSlaveActive}, 3'b111);
    extLevel = 16'h00B0;
    step(2);
    chk(spiSlaveActive, 1'b0);
    // spi master: miso forced in, sck and mosi carry spi values
    {spiMasterSelect, spiClockOut, spiMasterOut, outBitsB} = {3'b111, 8'h00};
    extDrive = 16'h0040;
    extLevel = 16'h0040;
    step(2);
    chk(pinOeB, 8'hBF);
    chk(pinOutB & 8'hA0, 8'hA0);
    chk(spiMasterIn, 1'b1);
    // compare output on bit 3, interrupt 2 input kept alive in sleep
    {spiEnableBit, dirBitsB, timer0CompareEnable, timer0CompareOutput} = {1'b0, 8'h08, 2'b11};
    {sleepInputDisable, extInterrupt2Enable} = 2'b11;
    extDrive = 16'h0007;
    extLevel = 16'h0006;
    step(2);
    chk(pinOeB, 8'h08);
    chk(pinOutB[3], 1'b1);
    chk(extInterrupt2Input, 1'b1);
    chk(portInB, 8'h04);
    dirBitsB = 8'h00;
    step(2);
    chk(pinOeB[3], 1'b0);
    // comparator pins left as inputs without pull-ups
    {sleepInputDisable, extInterrupt2Enable, timer0CompareEnable} = 3'b000;
    extDrive = 16'h000F;
    extLevel = 16'h000A;
    step(2);
    chk({comparatorNegativeInput, comparatorPositiveInput}, 2'b10);
    chk({timer1CountSource, timer0CountSource}, 2'b10);
    chk(pinOeB, 8'h00);
    // usart clock pin, driving then receiving
    {usartModeSelect, usartSyncClockOut, dirBitsB} = {2'b11, 8'h01};
    extDrive = 16'h0000;
    step(2);
    chk({pinOeB[0], pinOutB[0]}, 2'b11);
    dirBitsB = 8'h00;
    extDrive = 16'h0001;
    extLevel = 16'h0001;
    step(2);
    chk({pinOeB[0], usartSyncClockIn}, 2'b01);
    {usartModeSelect, dirBitsB} = {1'b0, 8'h01};
    extDrive = 16'h0000;
    step(2);
    chk(pinOutB[0], 1'b0);
    // port c: oscillator, jtag and two-wire data take their pins
    {timer2AsyncSelect, dirBitsC, outBitsC} = {1'b1, 8'hFF, 8'hFF};
    step(2);
    chk(pinOeC, 8'h3F);
    chk(pinPullupC & 8'hC0, 8'h00);
    {jtagEnable, twoWireEnableBit, twoWireDataPullLow, globalPullupDisable} = 4'b1111;
    extDrive = 16'h2C00;
    extLevel = 16'h2800;
    step(2);
    chk(pinOeC & 8'hEF, 8'h03);
    chk({pinOutC[1], jtagTdiIn}, 2'b01);
    chk(pinPullupC & 8'h2C, 8'h2C);
    {twoWireDataPullLow, globalPullupDisable} = 2'b00;
    step(2);
    chk({pinOeC[1], pinPullupC[1], twoWireDataIn}, 3'b011);
    chk(portInC, 8'h03);
    globalPullupDisable = 1'b1;
    step(2);
    chk(pinPullupC[1], 1'b0);
    // tap walk: reset, idle, select, capture, shift, exit
    repeat (5) tckPulse(1'b1);
    tckPulse(1'b0);
    tckPulse(1'b1);
    tckPulse(1'b0);
    chk(pinOeC[4], 1'b0);
    jtagTdoData = 1'b1;
    tckPulse(1'b0);
    chk({pinOeC[4], pinOutC[4], tdoShiftActive}, 3'b111);
    // tms moves with no test clock edge: state must hold
    extLevel[11] = 1'b1;
    step(4);
    chk(pinOeC[4], 1'b1);
    chk({jtagTmsIn, jtagTckIn}, 2'b11);
    tckPulse(1'b1);
    chk(pinOeC[4], 1'b0);
    finalReport;
  end
endmodule
`default_nettype wire
